/* File: design/mcg_master_clock.sv */
// master clock generation: bypass prescaler or digital pll from the
// oscillator pin, cpu/bus/system clocks, AXI4-Lite register slave
// assumes mclk (20 MHz) is much faster than the oscillator input
//
// Notes on behaviour
// [RL1] config register mode picks bypass or pll
// [RL2] cpu clock is master or master halved
// [RL3] cpu and bus controller share cpu clock
// [RL4] system clock equals cpu clock frequency
// [RL5] bypass divides by (in+1) times (out+1)
// [RL6] both dividers zero: master follows oscillator
// [RL7] input divider max 3, output max 14
// [RL8] mode 11 enables pll with multiplier
// [RL9] pll locks gradually, no abrupt steps
// [RL10] pll output divided by output divider plus one
// [RL11] vco band select, value 11 reserved
// [RL12] halved clock made from master edges
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module mcg_master_clock (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    // oscillator pin
    input  wire logic                       crystalInput,
    // generated clocks and vco band select
    output logic                            masterClock,
    output logic                            cpuClock,
    output logic                            busCtrlClock,
    output logic                            systemClock,
    output logic [1:0]                      vcoBand,
    // axi4-lite write address
    input  wire logic [mcg_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    // axi4-lite write data
    input  wire logic [mcg_pkg::AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // axi4-lite read address
    input  wire logic [mcg_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    // axi4-lite read data
    output logic [mcg_pkg::AXI_DW-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        oscPrev;
        logic        masterClk;
        logic        cpuClk;
        logic        busClk;
        logic        sysClk;
        logic [1:0]  mode;
        logic [1:0]  inDiv;
        logic [3:0]  outDiv;
        logic [4:0]  mult;
        logic [1:0]  band;
        logic        halve;
        logic [5:0]  halfCnt;
        logic [15:0] perCnt;
        logic [15:0] oscPer;
        logic [23:0] track;
        logic [23:0] acc;
        logic        locked;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
    } mcg_state_t;

    mcg_state_t st_ff;
    mcg_state_t nxt_st;
    logic       oscSync;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // overall prescale factor (in+1)*(out+1), at most 60
    function automatic logic [5:0] divProduct(input logic [1:0] i, input logic [3:0] o);
        logic [5:0] a;
        logic [5:0] b;
        a = {4'h0, i} + 6'h01;
        b = {2'h0, o} + 6'h01;
        return 6'(a * b);
    endfunction

    // word match of a byte address
    function automatic logic hitWord(input logic [7:0] addr, input logic [7:0] ofs);
        return addr[7:2] == ofs[7:2];
    endfunction

    // ------------------------------------------------------------
    // oscillator pin synchroniser
    // ------------------------------------------------------------
    mcg_sync2 u_osc_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (crystalInput),
        .dout  (oscSync)
    );

    // ------------------------------------------------------------
    // combinational decode
    // ------------------------------------------------------------
    logic        pllOn;
    logic [5:0]  nFactor;
    logic        oscEdge;
    logic        oscRise;
    logic [23:0] pnTarget;
    logic [6:0]  accStep;
    logic        wrTake;
    logic        rdTake;

    assign pllOn    = st_ff.mode == mcg_pkg::MODE_PLL;               // RL1
    assign nFactor  = divProduct(st_ff.inDiv, st_ff.outDiv);
    assign oscEdge  = oscSync ^ st_ff.oscPrev;
    assign oscRise  = oscSync & ~st_ff.oscPrev;
    assign pnTarget = {8'h00, st_ff.oscPer} * {18'h0_0000, nFactor};   // RL8
    assign accStep  = {1'b0, st_ff.mult, 1'b0} + 7'h02;
    assign wrTake   = s_axi_awvalid & s_axi_wvalid & ~st_ff.bValid;
    assign rdTake   = s_axi_arvalid & ~st_ff.rValid;

    // handshake outputs
    assign s_axi_awready = wrTake;
    assign s_axi_wready  = wrTake;
    assign s_axi_arready = ~st_ff.rValid;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [24:0] nAcc;
        logic [23:0] gap;
        logic [23:0] stepT;
        logic        mcNext;
        nAcc   = '0;
        gap    = '0;
        stepT  = '0;
        nxt_st = st_ff;
        nxt_st.oscPrev = oscSync;
        mcNext = st_ff.masterClk;

        // oscillator period in mclk cycles
        if (oscRise) begin
            nxt_st.oscPer = st_ff.perCnt + 16'h0001;
            nxt_st.perCnt = '0;
        end else if (st_ff.perCnt != 16'hFFFF) begin
            nxt_st.perCnt = st_ff.perCnt + 16'h0001;
        end

        if (!pllOn) begin
            // bypass prescaler
            nxt_st.acc    = '0;
            nxt_st.locked = 1'b0;
            if (nFactor == 6'h01) begin
                mcNext         = oscSync;                           // RL6
                nxt_st.halfCnt = '0;
            end else if (oscEdge) begin
                // toggle every N oscillator half periods
                if (st_ff.halfCnt >= nFactor - 6'h01) begin        // RL5
                    nxt_st.halfCnt = '0;
                    mcNext         = ~st_ff.masterClk;
                end else begin
                    nxt_st.halfCnt = st_ff.halfCnt + 6'h01;
                end
            end
        end else begin
            // pll: track slews toward oscPer*N, a period scaled by 1/(mult+1)
            nxt_st.halfCnt = '0;
            if (oscRise) begin
                if (st_ff.track < pnTarget) begin
                    gap   = pnTarget - st_ff.track;
                    stepT = (gap >> mcg_pkg::TRACK_SHIFT) == '0 ? 24'h00_0001
                          : gap >> mcg_pkg::TRACK_SHIFT;
                    nxt_st.track = st_ff.track + stepT;             // RL9
                end else if (st_ff.track > pnTarget) begin
                    gap   = st_ff.track - pnTarget;
                    stepT = (gap >> mcg_pkg::TRACK_SHIFT) == '0 ? 24'h00_0001
                          : gap >> mcg_pkg::TRACK_SHIFT;
                    nxt_st.track = st_ff.track - stepT;             // RL9
                end
            end
            nxt_st.locked = st_ff.track == pnTarget;
            // phase accumulator: half period = track / (2*(mult+1))
            if (st_ff.track != '0) begin
                nAcc = {1'b0, st_ff.acc} + {18'h0_0000, accStep};   // RL8
                if (nAcc >= {1'b0, st_ff.track}) begin              // RL10
                    nxt_st.acc = 24'(nAcc - {1'b0, st_ff.track});
                    mcNext     = ~st_ff.masterClk;
                end else begin
                    nxt_st.acc = nAcc[23:0];
                end
                if (nxt_st.acc >= nxt_st.track) begin
                    nxt_st.acc = '0;
                end
            end
        end
        nxt_st.masterClk = mcNext;

        // cpu clock: master, or toggled on each master rise
        if (st_ff.halve) begin
            if (mcNext && !st_ff.masterClk) begin                  // RL12
                nxt_st.cpuClk = ~st_ff.cpuClk;                     // RL2
            end
        end else begin
            nxt_st.cpuClk = mcNext;                                // RL2
        end
        nxt_st.busClk = nxt_st.cpuClk;                             // RL3
        nxt_st.sysClk = nxt_st.cpuClk;                             // RL4

        // register writes
        if (st_ff.bValid && s_axi_bready) begin
            nxt_st.bValid = 1'b0;
        end
        if (wrTake) begin
            nxt_st.bValid = 1'b1;
            nxt_st.bResp  = mcg_pkg::RESP_OKAY;
            if (hitWord(s_axi_awaddr, mcg_pkg::OFS_PLL_CONFIG)) begin
                if (s_axi_wstrb[0]) begin
                    // restart the prescaler so no stale count exceeds a new factor
                    nxt_st.halfCnt = '0;
                    nxt_st.mode  = s_axi_wdata[mcg_pkg::POS_MODE +: 2];
                    nxt_st.inDiv = s_axi_wdata[mcg_pkg::POS_INDIV +: 2];
                    // output divider saturates at 14
                    nxt_st.outDiv = s_axi_wdata[mcg_pkg::POS_OUTDIV +: 4]
                                    == mcg_pkg::OUTDIV_ILL ? mcg_pkg::OUTDIV_MAX
                                    : s_axi_wdata[mcg_pkg::POS_OUTDIV +: 4]; // RL7
                end
                if (s_axi_wstrb[1]) begin
                    nxt_st.mult = s_axi_wdata[mcg_pkg::POS_MULT +: 5];
                    nxt_st.band = s_axi_wdata[mcg_pkg::POS_VCOBAND +: 2];    // RL11
                end
            end else if (hitWord(s_axi_awaddr, mcg_pkg::OFS_SYS_CTRL2)) begin
                if (s_axi_wstrb[0]) begin
                    nxt_st.halve = s_axi_wdata[mcg_pkg::POS_HALVE];
                end
            end else if (!hitWord(s_axi_awaddr, mcg_pkg::OFS_CLK_STATUS)) begin
                nxt_st.bResp = mcg_pkg::RESP_SLVERR;
            end
        end

        // register reads
        if (st_ff.rValid && s_axi_rready) begin
            nxt_st.rValid = 1'b0;
        end
        if (rdTake) begin
            nxt_st.rValid = 1'b1;
            nxt_st.rResp  = mcg_pkg::RESP_OKAY;
            nxt_st.rData  = '0;
            if (hitWord(s_axi_araddr, mcg_pkg::OFS_PLL_CONFIG)) begin
                nxt_st.rData[mcg_pkg::POS_MODE +: 2]    = st_ff.mode;
                nxt_st.rData[mcg_pkg::POS_INDIV +: 2]   = st_ff.inDiv;
                nxt_st.rData[mcg_pkg::POS_OUTDIV +: 4]  = st_ff.outDiv;
                nxt_st.rData[mcg_pkg::POS_MULT +: 5]    = st_ff.mult;
                nxt_st.rData[mcg_pkg::POS_VCOBAND +: 2] = st_ff.band;
            end else if (hitWord(s_axi_araddr, mcg_pkg::OFS_SYS_CTRL2)) begin
                nxt_st.rData[mcg_pkg::POS_HALVE] = st_ff.halve;
            end else if (hitWord(s_axi_araddr, mcg_pkg::OFS_CLK_STATUS)) begin
                nxt_st.rData[mcg_pkg::POS_OSCPER +: 16] = st_ff.oscPer;
                nxt_st.rData[mcg_pkg::POS_BANDRSV] = st_ff.band == mcg_pkg::BAND_RSV; // RL11
                nxt_st.rData[mcg_pkg::POS_PLLON]   = pllOn;
                nxt_st.rData[mcg_pkg::POS_LOCKED]  = st_ff.locked;
            end else begin
                nxt_st.rResp = mcg_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops
    assign masterClock  = st_ff.masterClk;
    assign cpuClock     = st_ff.cpuClk;
    assign busCtrlClock = st_ff.busClk;
    assign systemClock  = st_ff.sysClk;
    assign vcoBand      = st_ff.band;
    assign s_axi_bvalid = st_ff.bValid;
    assign s_axi_bresp  = st_ff.bResp;
    assign s_axi_rvalid = st_ff.rValid;
    assign s_axi_rdata  = st_ff.rData;
    assign s_axi_rresp  = st_ff.rResp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    bypass_no_acc_a: assert property ($past(!pllOn) |-> st_ff.acc == '0) // RL1
        else $error("accumulator running in bypass");
    cpu_full_a: assert property ($past(!st_ff.halve) |-> cpuClock == masterClock) // RL2
        else $error("cpu clock differs from master clock");
    bus_clk_a: assert property (busCtrlClock == cpuClock) // RL3
        else $error("bus controller clock differs from cpu clock");
    sys_clk_a: assert property (systemClock == cpuClock) // RL4
        else $error("system clock differs from cpu clock");
    bypass_cnt_a: assert property (!pllOn |-> st_ff.halfCnt < nFactor) // RL5
        else $error("prescaler count beyond factor");
    bypass_direct_a: assert property (
        (!pllOn && nFactor == 6'h01) ##1 (!pllOn && nFactor == 6'h01)
        |-> masterClock == $past(oscSync)) // RL6
        else $error("master does not follow oscillator");
    outdiv_max_a: assert property (st_ff.outDiv != mcg_pkg::OUTDIV_ILL) // RL7
        else $error("output divider above limit");
    pll_acc_a: assert property (pllOn && st_ff.track != '0 |-> st_ff.acc < st_ff.track) // RL8
        else $error("pll accumulator out of range");
    pll_slew_a: assert property (
        pllOn && $past(pllOn) && $past(st_ff.track) < $past(pnTarget)
        && pnTarget == $past(pnTarget) |-> st_ff.track <= pnTarget) // RL9
        else $error("pll track overshoot");
    half_edge_a: assert property (
        $past(st_ff.halve) && $rose(cpuClock) |-> $rose(masterClock)) // RL12
        else $error("halved clock not on master rise");

endmodule

/* File: design/mcg_pkg.sv */
// master clock generation: shared constants, register map and field layout
// assumes a 20 MHz mclk and a 32-bit AXI4-Lite register bus
package mcg_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int          AXI_AW       = 8;
    localparam int          AXI_DW       = 32;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_PLL_CONFIG  = 8'h00;
    localparam logic [7:0]  OFS_SYS_CTRL2   = 8'h04;
    localparam logic [7:0]  OFS_CLK_STATUS  = 8'h08;

    // ------------------------------------------------------------
    // pll_config_register field positions
    // ------------------------------------------------------------
    localparam int          POS_MODE     = 0;
    localparam int          POS_INDIV    = 2;
    localparam int          POS_OUTDIV   = 4;
    localparam int          POS_MULT     = 8;
    localparam int          POS_VCOBAND  = 14;

    // ------------------------------------------------------------
    // system_control_two_reg and status field positions
    // ------------------------------------------------------------
    localparam int          POS_HALVE    = 0;
    localparam int          POS_OSCPER   = 0;
    localparam int          POS_BANDRSV  = 16;
    localparam int          POS_PLLON    = 17;
    localparam int          POS_LOCKED   = 18;

    // ------------------------------------------------------------
    // field values and limits
    // ------------------------------------------------------------
    localparam logic [1:0]  MODE_PLL     = 2'h3;
    localparam logic [1:0]  BAND_RSV     = 2'h3;
    localparam logic [3:0]  OUTDIV_MAX   = 4'hE;
    localparam logic [3:0]  OUTDIV_ILL   = 4'hF;
    localparam int          TRACK_SHIFT  = 4;

    // ------------------------------------------------------------
    // clock rate
    // ------------------------------------------------------------
    localparam int          MCLK_PERIOD_NS = 50;

endpackage

/* File: design/mcg_sync2.sv */
// two-flop synchroniser for the oscillator pin
// assumes din is asynchronous to mclk
`timescale 1ns/100ps
module mcg_sync2 (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // level in and out
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;
    logic sync_ff;

    // ------------------------------------------------------------
    // two stages, first read only by the second
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

/* File: tb/mcg_osc_model.sv */
// oscillator source that drives the crystal pin of the master clock block
// assumes the bench runs mclk at 50 ns; the source runs free from time zero
`timescale 1ns/100ps
module mcg_osc_model #(
    parameter int HIGH_NS = 150,
    parameter int LOW_NS  = 250
) (
    // oscillator pin
    output logic crystalInput
);
    // ------------------------------------------------------------
    // free-running source
    // ------------------------------------------------------------
    // fixed offset keeps its edges away from the rising mclk edge
    initial begin
        crystalInput = 1'b0;
        #7;
        forever begin
            #(LOW_NS) crystalInput = 1'b1;
            #(HIGH_NS) crystalInput = 1'b0;
        end
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the master clock block
// assumes the design package is compiled first and the oscillator model beside it
`timescale 1ns/100ps
module testbench;
    localparam int OSC_CYC  = 8;
    localparam int HIGH_CYC = 3;
    logic        mclk, rst_n, crystalInput, masterClock, cpuClock, busCtrlClock, systemClock;
    logic [1:0]  vcoBand, bresp, rresp;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rnd, d, w;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          n_errors, checked, per, hi, n, i, ii, oo;
    // ------------------------------------------------------------
    // design, oscillator and clock
    // ------------------------------------------------------------
    mcg_master_clock u_mcg_master_clock (.mclk(mclk), .rst_n(rst_n),
        .crystalInput(crystalInput), .masterClock(masterClock), .cpuClock(cpuClock),
        .busCtrlClock(busCtrlClock), .systemClock(systemClock), .vcoBand(vcoBand),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    mcg_osc_model u_mcg_osc_model (.crystalInput(crystalInput));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic int expPer(input int di, input int dout);
        return OSC_CYC * (di + 1) * (dout + 1);
    endfunction
    function automatic int expRises(input int win, input int m, input int nd);
        return win * (m + 1) / (OSC_CYC * nd);
    endfunction
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic near(input string what, input int exp, input int got);
        checked++;
        if (got < exp - 1 || got > exp + 1) begin
            n_errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // write one word, hold each channel until taken, then wait for the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s,
                      input logic [1:0] er);
        logic       aw, wd, b, ta, tw;
        logic [1:0] rs;
        aw = 1'b1;
        wd = 1'b1;
        b = 1'b1;
        rs = 2'h0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= dv;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (b) begin
            // sample the handshake while it stands, act after the edge
            @(negedge mclk);
            ta = aw && awready;
            tw = wd && wready;
            b = !bvalid;
            rs = bresp;
            @(posedge mclk);
            if (ta) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (tw) begin
                wd = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
        cmp("bresp", er, rs);
    endtask
    // read one word, data handed back, response compared
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] dv);
        logic       ar, ta, tr;
        logic [1:0] rs;
        ar = 1'b1;
        tr = 1'b0;
        rs = 2'h0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(negedge mclk);
            ta = ar && arready;
            tr = rvalid;
            dv = rdata;
            rs = rresp;
            @(posedge mclk);
            if (ta) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
        cmp("rresp", er, rs);
    endtask
    // period and high time of the second full period of a clock output
    task automatic meas(input bit cpu, output int p, output int h);
        int k;
        logic pv, c;
        p = 0;
        h = 0;
        k = 0;
        pv = cpu ? cpuClock : masterClock;
        for (int t = 0; t < 20000 && k < 3; t++) begin
            @(negedge mclk);
            c = cpu ? cpuClock : masterClock;
            if (c && !pv) k++;
            if (k == 2) p++;
            if (k == 2 && c) h++;
            pv = c;
        end
    endtask
    task automatic rises(input int win, output int cnt);
        logic pv;
        cnt = 0;
        pv = masterClock;
        repeat (win) begin
            @(negedge mclk);
            if (masterClock && !pv) cnt++;
            pv = masterClock;
        end
    endtask
    // ------------------------------------------------------------
    // derived clocks always equal the cpu clock
    // ------------------------------------------------------------
    always @(negedge mclk) begin
        if (rst_n === 1'b1) begin
            cmp("busCtrlClock", cpuClock, busCtrlClock);
            cmp("systemClock", cpuClock, systemClock);
        end
    end
    // watchdog sized well above the expected run of about 11000 cycles
    initial begin
        repeat (80000) @(posedge mclk);
        n_errors++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        n_errors = 0;
        checked = 0;
        rnd = 32'h0000_ef94;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        // reset values, unmapped place, read-only status
        rd(mcg_pkg::OFS_PLL_CONFIG, mcg_pkg::RESP_OKAY, d);
        cmp("cfg reset", 32'h0000_0000, d);
        rd(mcg_pkg::OFS_SYS_CTRL2, mcg_pkg::RESP_OKAY, d);
        cmp("sys reset", 32'h0000_0000, d);
        rd(8'h0C, mcg_pkg::RESP_SLVERR, d);
        wr(8'h0C, 32'h0000_0001, 4'hF, mcg_pkg::RESP_SLVERR);
        wr(mcg_pkg::OFS_CLK_STATUS, 32'hFFFF_FFFF, 4'hF, mcg_pkg::RESP_OKAY);
        // byte enables and the output divider ceiling
        wr(mcg_pkg::OFS_PLL_CONFIG, 32'hFFFF_FFFF, 4'b0010, mcg_pkg::RESP_OKAY);
        rd(mcg_pkg::OFS_PLL_CONFIG, mcg_pkg::RESP_OKAY, d);
        cmp("cfg high byte", 32'h0000_DF00, d);
        wr(mcg_pkg::OFS_PLL_CONFIG, 32'h0000_00F0, 4'b0001, mcg_pkg::RESP_OKAY);
        rd(mcg_pkg::OFS_PLL_CONFIG, mcg_pkg::RESP_OKAY, d);
        cmp("cfg outdiv", 32'h0000_DFE0, d);
        // every vco band, the reserved one flagged
        for (i = 0; i < 4; i++) begin
            wr(mcg_pkg::OFS_PLL_CONFIG, 32'(i) << 14, 4'hF, mcg_pkg::RESP_OKAY);
            cmp("vcoBand", 32'(i), 32'(vcoBand));
            rd(mcg_pkg::OFS_CLK_STATUS, mcg_pkg::RESP_OKAY, d);
            cmp("band flag", 32'(i == 3), 32'(d[mcg_pkg::POS_BANDRSV]));
        end
        // bypass divider: corner cases first, then random settings
        for (i = 0; i < 7; i++) begin
            rnd = lfsr(rnd);
            ii = (i == 1) ? 3 : (i == 2) ? 1 : (i < 3) ? 0 : int'(rnd[3:2]);
            oo = (i == 1) ? 14 : (i == 2) ? 2 : (i < 3) ? 0 : int'(rnd[7:4]) % 15;
            w = (rnd & 32'h0000_DF00) | (32'(oo) << 4) | (32'(ii) << 2) | 32'(i % 3);
            wr(mcg_pkg::OFS_PLL_CONFIG, w, 4'hF, mcg_pkg::RESP_OKAY);
            rd(mcg_pkg::OFS_PLL_CONFIG, mcg_pkg::RESP_OKAY, d);
            cmp("cfg readback", w, d);
            rd(mcg_pkg::OFS_CLK_STATUS, mcg_pkg::RESP_OKAY, d);
            cmp("pll flag", 32'h0, 32'(d[mcg_pkg::POS_PLLON]));
            meas(1'b0, per, hi);
            cmp("bypass period", 32'(expPer(ii, oo)), 32'(per));
            if (ii == 0 && oo == 0) cmp("direct high", 32'(HIGH_CYC), 32'(hi));
        end
        // cpu clock halved from master rising edges, then undivided again
        wr(mcg_pkg::OFS_PLL_CONFIG, 32'h0000_0004, 4'hF, mcg_pkg::RESP_OKAY);
        wr(mcg_pkg::OFS_SYS_CTRL2, 32'h0000_0001, 4'hF, mcg_pkg::RESP_OKAY);
        meas(1'b1, per, hi);
        cmp("halved period", 32'(2 * expPer(1, 0)), 32'(per));
        cmp("halved high", 32'(expPer(1, 0)), 32'(hi));
        wr(mcg_pkg::OFS_SYS_CTRL2, 32'h0000_0000, 4'hF, mcg_pkg::RESP_OKAY);
        meas(1'b1, per, hi);
        cmp("cpu period", 32'(expPer(1, 0)), 32'(per));
        // pll with two multipliers, input and output dividers both one
        for (i = 1; i < 4; i += 2) begin
            w = (32'(i) << 8) | 32'h0000_0017;
            wr(mcg_pkg::OFS_PLL_CONFIG, w, 4'hF, mcg_pkg::RESP_OKAY);
            repeat (3000) @(posedge mclk);
            rd(mcg_pkg::OFS_CLK_STATUS, mcg_pkg::RESP_OKAY, d);
            cmp("pll on locked", 32'h3, 32'(d[mcg_pkg::POS_LOCKED:mcg_pkg::POS_PLLON]));
            rises(1280, n);
            near("pll rises", expRises(1280, i, 4), n);
        end
        // back to bypass: the pll flag drops
        wr(mcg_pkg::OFS_PLL_CONFIG, 32'h0000_0000, 4'hF, mcg_pkg::RESP_OKAY);
        rd(mcg_pkg::OFS_CLK_STATUS, mcg_pkg::RESP_OKAY, d);
        cmp("pll off", 32'h0, 32'(d[mcg_pkg::POS_PLLON]));
        wrap_up();
    end
endmodule
